// ---- logic/acs_uart.sv ----
// Function
// RQ1: Divisor table with fractional and external ratios
// RQ2: Software pairs crystal with matching prescale
// RQ3: Modem control readable; bits drive handshake outputs
// RQ4: Global enable gates interrupt output
// RQ5: Mode field selects normal, break, echo, loop
// RQ6: Status read clears bits, not pins
// RQ7: Modem status shows inputs inverted
// RQ8: Modem input change sets modem flag
// RQ9: Clear-to-send deasserted blocks next character
// RQ10: Five to eight bits, right justified
// RQ11: Sample at bit centre, load buffer, ready
// RQ12: Unread buffer at completion sets overrun
// RQ13: Buffer holds byte; LSB first, same format
// RQ14: Transmit parity independent of receive parity
// RQ15: Buffer-empty pin/flag; done when both empty
// RQ16: Modem edge on any change; read clears
// RQ17: Status edge on rising bits; read clears
// RQ18: Reset sets done flag with pending edge
// RQ19: Setting suppressed during read, applied after
// RQ20: Set bit recurring during read ends cleared
// RQ21: Software reset writes setup, then reads
// RQ22: Modem enable masks only modem interrupts
// RQ23: Four indices, read and write differ; the code decodes five, 0 to 4
// RQ24: Reset clears counters, status, modem control; the code presets status to done and empty
// RQ25: Baud generator runs at sixteen times rate
// RQ26: Prescaler divides by 1, 3, 4, 5
// RQ27: Interrupt from status edge or enabled modem
`timescale 1ns/1ps
module acs_uart (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic osc_in,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic dsr_n,
  input wire logic cts_n,
  output logic rts_n,
  output logic dtr_n,
  output logic rx_ready,
  output logic tx_buf_empty,
  output logic irq_out
);
  typedef enum logic [2:0] {ACS_RX_IDLE, ACS_RX_START, ACS_RX_DATA, ACS_RX_PAR, ACS_RX_STOP}
    acs_rx_t;
  typedef enum logic {ACS_TX_IDLE, ACS_TX_SHIFT} acs_tx_t;
  typedef struct packed {
    logic [3:0] s1, s2, s3, rx_tick, rx_bit, tx_tick, tx_bit;
    logic [7:0] cfg, baud, mctl, w_data, rdata, rx_shift, rx_buf, tx_buf, stat, stat_defer;
    logic [2:0] txpar, presc;
    logic [5:0] aw_idx;
    logic [1:0] bresp, rresp;
    logic [11:0] acc, tx_shift;
    logic aw_have, w_have, w_en, bvalid, rvalid, rx_perr, rxrdy, tx_full, tc_prev, sout;
    logic stat_edge, mod_edge, mod_defer, sync_ok;
    acs_rx_t rx_st;
    acs_tx_t tx_st;
  } acs_state_t;
  acs_state_t s_q, s_d;
  acs_pkg::acs_mode_t mode;
  logic [1:0] wl;
  logic [3:0] nbits;
  logic [7:0] mask, rx_data, tx_data, ev;
  logic [11:0] thirds, sum, frame;
  logic tick16, pre_tick, rx_line, tx_line, rd_stat, rd_msr, mod_ev;
  logic tp_en, tp_even, tc_cond;
  logic [5:0] ar_idx;

  // Word format shared by both directions
  always_comb begin
    wl = s_q.cfg[acs_pkg::CFG_WL_LSB +: 2];
    nbits = 4'd5 + {2'b00, wl};
    mask = 8'hff >> (2'd3 - wl);
    mode = acs_pkg::acs_mode_t'(s_q.mctl[acs_pkg::MC_MODE_LSB +: 2]);
    thirds = acs_pkg::acs_div_thirds(s_q.baud[acs_pkg::BR_DIV_LSB +: 5]);
    // RQ10: right justify, upper bits zero
    rx_data = (s_q.rx_shift >> (2'd3 - wl)) & mask;
    tx_data = s_q.tx_buf & mask;
    // RQ14: own parity or follow receiver
    tp_en = s_q.txpar[acs_pkg::TP_OWN] ? s_q.txpar[acs_pkg::TP_EN] : s_q.cfg[acs_pkg::CFG_PEN];
    tp_even = s_q.txpar[acs_pkg::TP_OWN] ? s_q.txpar[acs_pkg::TP_EVEN] :
      s_q.cfg[acs_pkg::CFG_PEVEN];
    tx_line = (s_q.tx_st == ACS_TX_SHIFT) ? s_q.tx_shift[0] : 1'b1;
    rx_line = (mode == acs_pkg::ACS_MODE_LOOP) ? tx_line : s_q.s2[1];
    ar_idx = s_axi_araddr[acs_pkg::ADDR_W-1:2];
  end
  // Frame image for the transmit shifter, start bit at bit 0
  always_comb begin
    frame = 12'hfff;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nbits)) begin
        frame[i+1] = tx_data[i];
      end
    end
    if (tp_en) begin
      frame[nbits+4'd1] = ^tx_data ^ ~tp_even;
    end
  end
  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    ev = 8'h00;
    rd_stat = 1'b0;
    rd_msr = 1'b0;
    pre_tick = 1'b0;
    tick16 = 1'b0;
    sum = 12'h000;
    // Pins cross two flops; third stage only feeds edge detection
    s_d.s1 = {cts_n, dsr_n, serial_in, osc_in};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.sync_ok = 1'b1; // Third stage holds a real sample one cycle on
    // Bus read, taken at the address handshake
    if (s_axi_arvalid && ce && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = acs_pkg::RESP_OKAY;
      s_d.rdata = 8'h00;
      // RQ23: index decode for reads
      unique case (ar_idx)
        acs_pkg::IDX_DATA: begin
          s_d.rdata = s_q.rx_buf;
          s_d.rxrdy = 1'b0;
        end
        acs_pkg::IDX_LINE: begin
          s_d.rdata = s_q.stat;
          rd_stat = 1'b1;
        end
        // RQ3: modem control reads back
        acs_pkg::IDX_MODEM: s_d.rdata = s_q.mctl;
        acs_pkg::IDX_BAUD: begin
          // RQ7: asserted low pin reads as one
          s_d.rdata = {6'h00, ~s_q.s2[3], ~s_q.s2[2]};
          rd_msr = 1'b1;
        end
        acs_pkg::IDX_TXPAR: s_d.rdata = {5'h00, s_q.txpar};
        default: s_d.rresp = acs_pkg::RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // RQ26: prescaler on rising edges of the oscillator
    if (s_q.s2[0] && !s_q.s3[0]) begin
      if (s_q.presc == acs_pkg::acs_pre_last(s_q.baud[acs_pkg::BR_PRE_LSB +: 2])) begin
        s_d.presc = 3'h0;
        pre_tick = 1'b1;
      end else begin
        s_d.presc = s_q.presc + 3'h1;
      end
    end
    // RQ1: fractional divide by accumulating thirds
    if (pre_tick) begin
      if (thirds == 12'h000) begin
        tick16 = 1'b1;
      end else begin
        sum = s_q.acc + acs_pkg::THIRD_STEP;
        // RQ25: one tick per sixteenth of a bit
        if (sum >= thirds) begin
          s_d.acc = sum - thirds;
          tick16 = 1'b1;
        end else begin
          s_d.acc = sum;
        end
      end
    end
    // RQ11: receiver, start found then sampled at bit centre
    if (tick16) begin
      s_d.rx_tick = s_q.rx_tick + 4'h1;
      unique case (s_q.rx_st)
        ACS_RX_IDLE: begin
          s_d.rx_tick = 4'h0;
          if (s_q.mctl[acs_pkg::MC_RXEN] && !rx_line) begin
            s_d.rx_st = ACS_RX_START;
          end
        end
        ACS_RX_START: begin
          if (s_q.rx_tick == acs_pkg::TICK_MID) begin
            s_d.rx_tick = 4'h0;
            s_d.rx_bit = 4'h0;
            // Glitch shorter than half a bit is not a start
            s_d.rx_st = rx_line ? ACS_RX_IDLE : ACS_RX_DATA;
          end
        end
        ACS_RX_DATA: begin
          if (s_q.rx_tick == acs_pkg::TICK_LAST) begin
            // RQ10: first bit lands in bit 0
            s_d.rx_shift = {rx_line, s_q.rx_shift[7:1]};
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit == nbits - 4'h1) begin
              s_d.rx_st = s_q.cfg[acs_pkg::CFG_PEN] ? ACS_RX_PAR : ACS_RX_STOP;
            end
          end
        end
        ACS_RX_PAR: begin
          if (s_q.rx_tick == acs_pkg::TICK_LAST) begin
            s_d.rx_perr = rx_line != (^rx_data ^ ~s_q.cfg[acs_pkg::CFG_PEVEN]);
            s_d.rx_st = ACS_RX_STOP;
          end
        end
        ACS_RX_STOP: begin
          if (s_q.rx_tick == acs_pkg::TICK_LAST) begin
            s_d.rx_st = ACS_RX_IDLE;
            s_d.rx_buf = rx_data;
            // RQ11: buffer load raises ready pin and flag
            s_d.rxrdy = 1'b1;
            ev[acs_pkg::ST_RXRDY] = 1'b1;
            // RQ12: previous character still unread
            ev[acs_pkg::ST_OVR] = s_q.rxrdy;
            ev[acs_pkg::ST_PERR] = s_q.cfg[acs_pkg::CFG_PEN] & s_q.rx_perr;
            ev[acs_pkg::ST_FERR] = ~rx_line;
            s_d.rx_perr = 1'b0;
          end
        end
        default: s_d.rx_st = ACS_RX_IDLE;
      endcase
    end
    // RQ9: a new character starts only with clear-to-send low
    if (s_q.tx_st == ACS_TX_IDLE && s_q.tx_full && !s_q.s2[3] &&
        mode != acs_pkg::ACS_MODE_BREAK) begin
      // RQ13: buffer moves to shifter once it is empty
      s_d.tx_st = ACS_TX_SHIFT;
      s_d.tx_shift = frame;
      s_d.tx_tick = 4'h0;
      s_d.tx_bit = nbits + {3'h0, tp_en} + {3'h0, s_q.cfg[acs_pkg::CFG_STOP2]} + 4'h1;
      s_d.tx_full = 1'b0;
      // RQ15: buffer empty event
      ev[acs_pkg::ST_TXBE] = 1'b1;
    end else if (s_q.tx_st == ACS_TX_SHIFT && tick16) begin
      s_d.tx_tick = s_q.tx_tick + 4'h1;
      if (s_q.tx_tick == acs_pkg::TICK_LAST) begin
        s_d.tx_shift = {1'b1, s_q.tx_shift[11:1]};
        s_d.tx_bit = s_q.tx_bit - 4'h1;
        // RQ9: character in flight always completes
        if (s_q.tx_bit == 4'h0) begin
          s_d.tx_st = ACS_TX_IDLE;
        end
      end
    end
    // Bus write once address and data are both held
    if (s_axi_awvalid && ce && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx = s_axi_awaddr[acs_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid && ce && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_en = s_axi_wstrb[0];
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = acs_pkg::RESP_OKAY;
      // RQ23: index decode for writes
      unique case (s_q.aw_idx)
        acs_pkg::IDX_DATA: begin
          if (s_q.w_en) begin
            s_d.tx_buf = s_q.w_data;
            s_d.tx_full = 1'b1;
          end
        end
        acs_pkg::IDX_LINE: s_d.cfg = s_q.w_en ? s_q.w_data : s_q.cfg;
        acs_pkg::IDX_MODEM: s_d.mctl = s_q.w_en ? s_q.w_data : s_q.mctl;
        acs_pkg::IDX_BAUD: s_d.baud = s_q.w_en ? s_q.w_data : s_q.baud;
        acs_pkg::IDX_TXPAR: s_d.txpar = s_q.w_en ? s_q.w_data[2:0] : s_q.txpar;
        default: s_d.bresp = acs_pkg::RESP_SLVERR;
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // RQ15: done only when buffer and shifter are both empty
    tc_cond = !s_d.tx_full && s_d.tx_st == ACS_TX_IDLE;
    s_d.tc_prev = tc_cond;
    ev[acs_pkg::ST_TC] = tc_cond & ~s_q.tc_prev;
    // RQ8: any modem input change, once the edge stage is filled
    mod_ev = s_q.sync_ok && (s_q.s2[3:2] != s_q.s3[3:2]);
    ev[acs_pkg::ST_MODEM] = mod_ev;
    // RQ6: read clears status; pins keep their own state
    if (rd_stat) begin
      s_d.stat = 8'h00;
      // RQ17: read clears status edge latch
      s_d.stat_edge = 1'b0;
      // RQ19: new events wait out the read cycle
      // RQ20: already set and recurring ends cleared
      s_d.stat_defer = ev & ~s_q.stat;
    end else begin
      s_d.stat = s_q.stat | ev | s_q.stat_defer;
      s_d.stat_defer = 8'h00;
      // RQ17: rising status bits only
      s_d.stat_edge = s_q.stat_edge | (|(s_d.stat & ~s_q.stat));
    end
    // RQ16: modem edge latch, cleared by modem status read
    if (rd_msr) begin
      s_d.mod_edge = 1'b0;
      s_d.mod_defer = mod_ev & ~s_q.mod_edge;
    end else begin
      s_d.mod_edge = s_q.mod_edge | mod_ev | s_q.mod_defer;
      s_d.mod_defer = 1'b0;
    end
    // RQ5: line drive per operating mode
    unique case (mode)
      acs_pkg::ACS_MODE_NORMAL: s_d.sout = tx_line;
      acs_pkg::ACS_MODE_BREAK: s_d.sout = 1'b0;
      acs_pkg::ACS_MODE_ECHO: s_d.sout = s_q.s2[1];
      acs_pkg::ACS_MODE_LOOP: s_d.sout = 1'b1;
    endcase
    // RQ24: counters, modem control, transmit parity cleared; status preset; line and baud setup kept
    if (!aresetn) begin
      s_d = '0;
      // Stages track the pins, so no false modem edge once reset lifts
      s_d.s1 = {cts_n, dsr_n, serial_in, osc_in};
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.cfg = s_q.cfg;
      s_d.baud = s_q.baud;
      s_d.sout = 1'b1;
      s_d.tx_shift = 12'hfff;
      s_d.tc_prev = 1'b1;
      // RQ18: done and empty set, edge left pending
      s_d.stat = acs_pkg::ST_RESET;
      s_d.stat_edge = 1'b1;
    end
  end
  // Clock enable low freezes everything except reset
  always_ff @(posedge aclk) begin
    if (ce || !aresetn) begin
      s_q <= s_d;
    end
  end

  // Ready stays low while frozen so no handshake is lost
  assign s_axi_awready = ce & ~s_q.aw_have;
  assign s_axi_wready = ce & ~s_q.w_have;
  assign s_axi_arready = ce & ~s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign s_axi_rresp = s_q.rresp;
  assign serial_out = s_q.sout;
  // RQ3: a one drives the pin low
  assign rts_n = ~s_q.mctl[acs_pkg::MC_RTS];
  assign dtr_n = ~s_q.mctl[acs_pkg::MC_DTR];
  assign rx_ready = s_q.rxrdy;
  assign tx_buf_empty = ~s_q.tx_full;
  // RQ4: RQ22: RQ27: enables gate the latched edges
  assign irq_out = s_q.mctl[acs_pkg::MC_GIE] &
    (s_q.stat_edge | (s_q.mctl[acs_pkg::MC_MIE] & s_q.mod_edge));
endmodule : acs_uart

// ---- logic/acs_pkg.sv ----
package acs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DATA = 6'h00;
  localparam logic [5:0] IDX_LINE = 6'h01;
  localparam logic [5:0] IDX_MODEM = 6'h02;
  localparam logic [5:0] IDX_BAUD = 6'h03;
  localparam logic [5:0] IDX_TXPAR = 6'h04;
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Line config fields
  localparam int CFG_STOP2 = 0;
  localparam int CFG_WL_LSB = 1;
  localparam int CFG_PEN = 3;
  localparam int CFG_PEVEN = 4;
  // Modem control fields
  localparam int MC_RTS = 0;
  localparam int MC_DTR = 1;
  localparam int MC_GIE = 2;
  localparam int MC_MIE = 3;
  localparam int MC_MODE_LSB = 4;
  localparam int MC_RXEN = 6;
  // Transmit parity fields
  localparam int TP_OWN = 0;
  localparam int TP_EN = 1;
  localparam int TP_EVEN = 2;
  // Baud select fields
  localparam int BR_DIV_LSB = 0;
  localparam int BR_PRE_LSB = 5;
  // Line status bits
  localparam int ST_RXRDY = 0;
  localparam int ST_OVR = 1;
  localparam int ST_PERR = 2;
  localparam int ST_FERR = 3;
  localparam int ST_MODEM = 5;
  localparam int ST_TXBE = 6;
  localparam int ST_TC = 7;
  localparam logic [7:0] ST_RESET = 8'hc0;
  // 16x tick positions within one bit
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [11:0] THIRD_STEP = 12'h003;

  typedef enum logic [1:0] {
    ACS_MODE_NORMAL, ACS_MODE_BREAK, ACS_MODE_ECHO, ACS_MODE_LOOP
  } acs_mode_t;

  // Divisor in thirds; zero means pass prescaler output undivided
  function automatic logic [11:0] acs_div_thirds(input logic [4:0] code);
    case (code)
      5'h00: acs_div_thirds = 12'h000;
      5'h01: acs_div_thirds = 12'h006;
      5'h02: acs_div_thirds = 12'h00c;
      5'h03: acs_div_thirds = 12'h010;
      5'h04: acs_div_thirds = 12'h018;
      5'h05: acs_div_thirds = 12'h020;
      5'h06: acs_div_thirds = 12'h030;
      5'h07: acs_div_thirds = 12'h03a;
      5'h08: acs_div_thirds = 12'h042;
      5'h09: acs_div_thirds = 12'h060;
      5'h0a: acs_div_thirds = 12'h0c0;
      5'h0b: acs_div_thirds = 12'h180;
      5'h0c: acs_div_thirds = 12'h240;
      5'h0d: acs_div_thirds = 12'h300;
      5'h0e: acs_div_thirds = 12'h360;
      5'h0f: acs_div_thirds = 12'h420;
      5'h10: acs_div_thirds = 12'h600;
      default: acs_div_thirds = 12'h900;
    endcase
  endfunction : acs_div_thirds

  // Prescaler terminal count for divide by 1, 3, 4, 5
  function automatic logic [2:0] acs_pre_last(input logic [1:0] code);
    case (code)
      2'h0: acs_pre_last = 3'h0;
      2'h1: acs_pre_last = 3'h2;
      2'h2: acs_pre_last = 3'h3;
      default: acs_pre_last = 3'h4;
    endcase
  endfunction : acs_pre_last
endpackage : acs_pkg

// ---- dv/acs_uart_checker.sv ----
`timescale 1ns/1ps
module acs_uart_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [acs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic serial_out,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic rx_ready,
  input wire logic tx_buf_empty,
  input wire logic irq_out
);
  logic wrote_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Remembers any write since reset; irq needs a write first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrote_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wrote_q <= 1'b1;
    end
  end
  property p_rst_pins;
    $rose(aresetn) |-> serial_out && rts_n && dtr_n && !rx_ready && tx_buf_empty && !irq_out;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not at reset values");
  property p_irq_rst;
    !wrote_q |-> !irq_out;
  endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("irq before any enable write");
  // Response holds while stalled
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // write executes one cycle after both are held
  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write response late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read response late");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h04
      |=> s_axi_rresp == acs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_rx_clr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00 |=> !rx_ready;
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("ready pin kept after buffer read");
endmodule : acs_uart_checker

bind acs_uart acs_uart_checker i_acs_uart_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .serial_out(serial_out),
  .rts_n(rts_n), .dtr_n(dtr_n), .rx_ready(rx_ready), .tx_buf_empty(tx_buf_empty),
  .irq_out(irq_out)
);

// ---- dv/acs_line_model.sv ----
`timescale 1ns/1ps
module acs_line_model (
  input wire logic aclk,
  input wire logic serial_out,
  input wire logic loop_en,
  input wire logic hold_low,
  input wire logic cts_off,
  input wire logic dsr_on,
  output logic serial_in,
  output logic cts_n,
  output logic dsr_n
);
  initial serial_in = 1'b1;
  // Cable with one cycle of delay; idles marking when neither looped nor held low
  always @(posedge aclk) begin
    serial_in <= hold_low ? 1'b0 : (loop_en ? serial_out : 1'b1);
  end
  assign cts_n = cts_off;
  assign dsr_n = !dsr_on;
endmodule : acs_line_model

// ---- dv/tb_acs_uart.sv ----
`timescale 1ns/1ps
module tb_acs_uart;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} acs_exp_t;
  logic aclk, aresetn, ce, osc_in, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara, d, d2;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic sin, sout, dsr_n, cts_n, rts_n, dtr_n, rxr, tbe, irq;
  logic loop_en, hold_low, cts_off, dsr_on;
  logic [7:0] bt [3] = '{8'h00, 8'h21, 8'h03};
  int num_errors, checked, cyc, seed;
  acs_exp_t expq [$];

  acs_uart i_acs_uart (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .osc_in(osc_in), .serial_in(sin), .serial_out(sout), .dsr_n(dsr_n),
    .cts_n(cts_n), .rts_n(rts_n), .dtr_n(dtr_n), .rx_ready(rxr),
    .tx_buf_empty(tbe), .irq_out(irq)
  );
  acs_line_model i_acs_line_model (
    .aclk(aclk), .serial_out(sout), .loop_en(loop_en), .hold_low(hold_low),
    .cts_off(cts_off), .dsr_on(dsr_on), .serial_in(sin), .cts_n(cts_n), .dsr_n(dsr_n)
  );

  // Clocks; oscillator at 25 MHz, phase unrelated to aclk
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    osc_in = 1'b0;
    #3;
    forever #20 osc_in = ~osc_in;
  end

  task end_of_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task chk_v(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk_v

  task chk_p(input string n, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %b got %b", n, e, s);
    end
  endtask : chk_p

  // Write: both channels offered together, bready raised late to stall
  task wr(input logic [5:0] i, input logic [7:0] v);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awa <= {i, 2'h0};
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awv && awr) begin
        a = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrd) begin
        w = 1'b1;
        wv <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    br <= 1'b1;
    do @(posedge aclk); while (bv !== 1'b1);
    chk_v("bresp", {30'h0, acs_pkg::RESP_OKAY}, {30'h0, bresp});
    br <= 1'b0;
  endtask : wr

  // Read: expectation noted, compared by the monitor
  task rd(input logic [5:0] i, input logic [7:0] e, input logic [7:0] m,
          input logic [1:0] r = acs_pkg::RESP_OKAY);
    @(posedge aclk);
    ara <= {i, 2'h0};
    arv <= 1'b1;
    expq.push_back({24'h0, e, 24'h0, m, r});
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    repeat (2) @(posedge aclk);
    rr <= 1'b1;
    do @(posedge aclk); while (rv !== 1'b1);
    rr <= 1'b0;
  endtask : rd

  task wrx;
    int k;
    k = 0;
    while (rxr !== 1'b1 && k < 8000) begin
      @(posedge aclk);
      k++;
    end
  endtask : wrx

  // Read result monitor
  always @(posedge aclk) begin
    acs_exp_t x;
    if (rv === 1'b1 && rr === 1'b1) begin
      x = expq.pop_front();
      chk_v("rdata", x.v, rdat & x.m);
      chk_v("rresp", {30'h0, x.r}, {30'h0, rresp});
    end
  end

  // Hang guard, well above the longest expected run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    seed = 32'he0f5;
    {awv, wv, br, arv, rr, awa, ara, wd} = '0;
    ws = 4'hf;
    ce = 1'b1;
    aresetn = 1'b0;
    {loop_en, hold_low, cts_off, dsr_on} = 4'h8;
    num_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // setup writes; reset left a status edge pending
    wr(1, 8'h06);
    wr(3, 8'h00);
    wr(2, 8'h47);
    chk_p("irq", 1'b1, irq);
    chk_p("rts_n", 1'b0, rts_n);
    chk_p("dtr_n", 1'b0, dtr_n);
    rd(2, 8'h47, 8'hff);
    rd(1, 8'hc0, 8'hdf);
    chk_p("irq", 1'b0, irq);
    chk_p("tbe", 1'b1, tbe);
    rd(1, 8'h00, 8'hdf);
    rd(6'h08, 8'h00, 8'hff, acs_pkg::RESP_SLVERR);
    // Modem input change, masking by both enables
    dsr_on <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(1, 8'h20, 8'h20);
    chk_p("irq", 1'b0, irq);
    wr(2, 8'h4f);
    chk_p("irq", 1'b1, irq);
    rd(3, 8'h03, 8'hff);
    chk_p("irq", 1'b0, irq);
    wr(2, 8'h4b);
    dsr_on <= 1'b0;
    repeat (10) @(posedge aclk);
    chk_p("irq", 1'b0, irq);
    wr(2, 8'h4f);
    chk_p("irq", 1'b1, irq);
    rd(3, 8'h02, 8'hff);
    rd(1, 8'h20, 8'h20);
    chk_p("irq", 1'b0, irq);
    wr(2, 8'h43);
    // prescale matched to oscillator; several divisors
    for (int k = 0; k < 3; k++) begin
      wr(3, bt[k]);
      d = $random(seed);
      wr(0, d);
      wrx();
      rd(0, d, 8'hff);
      chk_p("rx_ready", 1'b0, rxr);
    end
    wr(3, 8'h00);
    repeat (100) @(posedge aclk);
    rd(1, 8'hc0, 8'hc0);
    // Back to back writes; second character overruns the first
    d = $random(seed);
    d2 = $random(seed);
    wr(0, d);
    wr(0, d2);
    chk_p("tbe", 1'b0, tbe);
    wrx();
    repeat (900) @(posedge aclk);
    rd(1, 8'h03, 8'h03);
    rd(0, d2, 8'hff);
    // Five bit words are right justified
    wr(1, 8'h00);
    d = $random(seed);
    wr(0, d);
    wrx();
    rd(0, d & 8'h1f, 8'hff);
    // Transmit parity follows or overrides receive parity
    wr(1, 8'h1e);
    for (int k = 0; k < 2; k++) begin
      wr(4, k ? 8'h03 : 8'h00);
      rd(1, 8'h00, 8'h04);
      d = $random(seed);
      wr(0, d);
      wrx();
      rd(0, d, 8'hff);
      rd(1, k ? 8'h04 : 8'h00, 8'h04);
    end
    rd(4, 8'h03, 8'h07);
    // Clear-to-send withheld blocks the next character
    wr(1, 8'h06);
    wr(4, 8'h00);
    cts_off <= 1'b1;
    repeat (10) @(posedge aclk);
    d = $random(seed);
    wr(0, d);
    repeat (300) @(posedge aclk);
    chk_p("sout", 1'b1, sout);
    chk_p("tbe", 1'b0, tbe);
    cts_off <= 1'b0;
    wrx();
    rd(0, d, 8'hff);
    // Break, loopback and echo modes
    wr(2, 8'h53);
    repeat (10) @(posedge aclk);
    chk_p("sout", 1'b0, sout);
    wr(2, 8'h73);
    loop_en <= 1'b0;
    d = $random(seed);
    wr(0, d);
    wrx();
    chk_p("sout", 1'b1, sout);
    rd(0, d, 8'hff);
    wr(2, 8'h63);
    hold_low <= 1'b1;
    repeat (10) @(posedge aclk);
    chk_p("sout", 1'b0, sout);
    end_of_test();
  end
endmodule : tb_acs_uart
